// ===== rtl/sra_engine.sv
// Structured reassembly engine: signalling, slip handling, counters
// Assumes cells arrive as bytes, one per cycle, with a start marker;
// entry table sits in flip-flops indexed by channel
`timescale 1ns/100ps
`include "sra_regs.svh"
module sra_engine #(
  parameter int CH    = 8,
  parameter int WPW   = 8,
  parameter int ADW   = 14,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Cell byte stream from the cell interface
  input  wire logic             cell_valid_in,
  output logic                  cell_ready_out,
  input  wire logic [7:0]       cell_byte_in,
  input  wire logic             cell_start_in,
  input  wire logic             cell_seq_odd_in,
  input  wire logic             cell_csi_in,
  // Circuit configuration
  input  wire logic             vc_startup_in,
  input  wire logic [2:0]       cas_ctrl_in,
  input  wire logic             e1_mode_in,
  input  wire logic             sn_sync_in,
  input  wire logic             reframe_pend_in,
  input  wire logic [$clog2(CH)-1:0] last_entry_in,
  input  wire logic [WPW-1:0]   slip_ptr_in,
  input  wire logic [WPW-1:0]   max_lead_in,
  input  wire logic [WPW-1:0]   read_ptr_in,
  input  wire logic             adaptive_en_in,
  input  wire logic             srts_en_in,
  input  wire logic [ADW-1:0]   vc_struct_addr_in,
  // Entry table load from software
  input  wire logic             tbl_we_in,
  input  wire logic [$clog2(CH)-1:0] tbl_idx_in,
  input  wire logic [3:0]       tbl_nibble_in,
  input  wire logic [11:0]      tbl_base_in,
  // Host register port
  input  wire logic             reg_rd_in,
  input  wire logic             reg_wr_in,
  input  wire logic [ADW-1:0]   reg_addr_in,
  input  wire logic [15:0]      reg_wdata_in,
  output logic [15:0]           reg_rdata_out,
  // Circular buffer write to the output module
  output logic                  buf_we_out,
  output logic [11+WPW:0]       buf_addr_out,
  output logic [15:0]           buf_data_out,
  input  wire logic             buf_ready_in,
  // Status and clock recovery
  output logic                  changed_flag_out,
  output logic [15:0]           underrun_cnt_out,
  output logic [15:0]           overflow_cnt_out,
  output logic                  service_req_out,
  output logic                  phase_valid_out,
  output logic [WPW-1:0]        phaseword_out,
  output logic                  rts_valid_out,
  output logic [3:0]            rts_out
);
  import sra_pkg::*;
  localparam int CW = $clog2(CH);

  // ============================================================
  // Entry table and counters
  logic [3:0]     nibble [CH];
  logic [11:0]    base   [CH];
  logic [CW-1:0]  cur_entry;
  logic [4:0]     cur_frame;
  logic [WPW-1:0] wr_ptr;
  logic           first_cell;
  logic           mf_pending;
  logic [15:0]    cell_count;
  logic [15:0]    vc_count;
  logic [15:0]    enable_reg;
  logic [15:0]    source_reg;
  logic           overall_roll;
  logic           vc_roll;
  logic [1:0]     rts_bits;
  logic [3:0]     rts_shift;

  // ============================================================
  // Decode
  wire take      = cell_valid_in && cell_ready_out;
  wire last_ch   = (cur_entry == last_entry_in);
  wire [4:0] cas_frame = e1_mode_in ? `SRA_E1_CAS_FRAME
                                    : `SRA_DS1_CAS_FRAME;
  wire cas_on    = cas_ctrl_in[`SRA_CAS_PROCESS_BIT];
  wire in_cas    = cas_on && (cur_frame == cas_frame - 5'd1);
  wire cas_ok    = in_cas && sn_sync_in && !reframe_pend_in;
  wire [3:0] rx_nib = cell_byte_in[3:0];
  wire cas_write = take && cas_ok &&
                   !cas_ctrl_in[`SRA_CAS_USER_BIT];
  wire cas_diff  = take && cas_ok && cas_ctrl_in[`SRA_CAS_COMPARE_BIT] &&
                   (rx_nib != nibble[cur_entry]);
  wire [WPW-1:0] lead = wr_ptr - read_ptr_in;
  sra_slip_t slip;
  assign slip = (lead == '0)        ? SRA_UNDERRUN :
                (lead > max_lead_in) ? SRA_OVERFLOW : SRA_OKAY;
  wire check    = take && cell_start_in && !first_cell &&
                  !vc_startup_in;
  wire slipped  = check && (slip != SRA_OKAY);
  wire [WPW-1:0] use_ptr = slipped ? slip_ptr_in : wr_ptr;
  wire payload  = take && !in_cas;
  wire mf_bit   = cas_on && mf_pending;
  wire [15:0] entry = {mf_bit, 1'b0, use_ptr[WPW-1 -: 2],
                       nibble[cur_entry], cell_byte_in};
  wire cell_tick = take && cell_start_in;
  wire vc_wrap   = cell_tick && (vc_count == 16'hffff);

  // ============================================================
  // Byte stream buffering toward the output module
  logic              fifo_out_valid;
  logic [11+WPW+16:0] fifo_out_data;
  logic              fifo_in_ready;
  sra_fifo #(.WIDTH(12+WPW+16), .DEPTH(DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (payload),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({base[cur_entry], use_ptr, entry}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (buf_ready_in),
    .out_data_out  (fifo_out_data)
  );
  // Back-pressure stalls the cell source while the buffer is full
  assign cell_ready_out = fifo_in_ready;

  // ============================================================
  // Channel, frame and pointer advance
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur_entry  <= '0;
      cur_frame  <= '0;
      wr_ptr     <= '0;
      first_cell <= 1'b1;
      mf_pending <= 1'b0;
    end else if (vc_startup_in) begin
      wr_ptr     <= slip_ptr_in;
      first_cell <= 1'b1;
      cur_entry  <= '0;
      cur_frame  <= '0;
    end else if (take) begin
      if (cell_start_in) first_cell <= 1'b0;
      if (last_ch) begin
        cur_entry <= '0;
        wr_ptr    <= use_ptr + 1'b1;
        if (in_cas) begin
          cur_frame  <= '0;
          mf_pending <= 1'b1;
        end else begin
          cur_frame  <= cur_frame + 5'd1;
          mf_pending <= 1'b0;
        end
      end else begin
        cur_entry <= cur_entry + 1'b1;
        wr_ptr    <= use_ptr;
      end
    end
  end

  // ============================================================
  // Entry table
  // Cleared at reset so unloaded channels never send unknown nibbles
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < CH; i++) begin
        nibble[i] <= 4'h0;
        base[i]   <= 12'h000;
      end
    end else if (tbl_we_in) begin
      nibble[tbl_idx_in] <= tbl_nibble_in;
      base[tbl_idx_in]   <= tbl_base_in;
    end else if (cas_write) begin
      nibble[cur_entry]  <= rx_nib;
    end
  end

  // ============================================================
  // Statistics, counters and registers
  wire hit_en  = reg_addr_in == `SRA_SERVICE_ENABLE_ADDR;
  wire hit_st  = reg_addr_in == `SRA_CELL_COUNT_STATUS_ADDR;
  wire clr_all = reg_wr_in && hit_st &&
                 reg_wdata_in[`SRA_OVERALL_ROLL_BIT];
  wire clr_vc  = reg_wr_in && hit_st && reg_wdata_in[`SRA_VC_ROLL_BIT];
  wire all_wrap = cell_tick && (cell_count == 16'hffff);
  wire [15:0] rd_mux =
    (reg_addr_in == `SRA_SERVICE_ENABLE_ADDR)    ? enable_reg :
    (reg_addr_in == `SRA_SERVICE_SOURCE_ADDR)    ? source_reg :
    hit_st ? {14'h0000, vc_roll, overall_roll} :
    (reg_addr_in == `SRA_CELL_COUNT_ADDR)        ? cell_count : 16'h0000;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cell_count       <= '0;
      vc_count         <= '0;
      enable_reg       <= `SRA_ENABLE_RESET;
      source_reg       <= '0;
      overall_roll     <= 1'b0;
      vc_roll          <= 1'b0;
      changed_flag_out <= 1'b0;
      underrun_cnt_out <= '0;
      overflow_cnt_out <= '0;
      service_req_out  <= 1'b0;
      reg_rdata_out    <= '0;
    end else begin
      if (cell_tick) cell_count <= cell_count + 16'h0001;
      if (cell_tick) vc_count   <= vc_count + 16'h0001;
      if (reg_wr_in && hit_en) enable_reg <= reg_wdata_in;
      // Set wins over a same-cycle clear
      if (all_wrap) overall_roll <= 1'b1;
      else if (clr_all) overall_roll <= 1'b0;
      if (vc_wrap) begin
        vc_roll    <= 1'b1;
        source_reg <= 16'(vc_struct_addr_in);
      end else if (clr_vc) vc_roll <= 1'b0;
      if (cas_diff) changed_flag_out <= 1'b1;
      if (slipped && slip == SRA_UNDERRUN)
        underrun_cnt_out <= underrun_cnt_out + 16'h0001;
      if (slipped && slip == SRA_OVERFLOW)
        overflow_cnt_out <= overflow_cnt_out + 16'h0001;
      service_req_out <=
        (overall_roll && enable_reg[`SRA_OVERALL_ROLL_BIT]) ||
        (vc_roll && enable_reg[`SRA_VC_ROLL_BIT]);
      reg_rdata_out <= reg_rd_in ? rd_mux : reg_rdata_out;
    end
  end

  // ============================================================
  // Output write port and clock recovery
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      buf_we_out      <= 1'b0;
      buf_addr_out    <= '0;
      buf_data_out    <= '0;
      phase_valid_out <= 1'b0;
      phaseword_out   <= '0;
      rts_valid_out   <= 1'b0;
      rts_out         <= '0;
      rts_bits        <= '0;
      rts_shift       <= '0;
    end else begin
      buf_we_out   <= fifo_out_valid && buf_ready_in;
      buf_addr_out <= fifo_out_data[11+WPW+16:16];
      buf_data_out <= fifo_out_data[15:0];
      phase_valid_out <= adaptive_en_in && cell_tick;
      phaseword_out   <= lead;
      rts_valid_out   <= 1'b0;
      if (srts_en_in && cell_tick && cell_seq_odd_in) begin
        rts_shift <= {rts_shift[2:0], cell_csi_in};
        rts_bits  <= rts_bits + 2'd1;
        if (rts_bits == 2'd3) begin
          rts_out       <= {rts_shift[2:0], cell_csi_in};
          rts_valid_out <= 1'b1;
        end
      end
    end
  end

  // ============================================================
  // Checks
  a_startup_ptr: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    vc_startup_in |=> wr_ptr == $past(slip_ptr_in))
    else $error("write pointer not loaded at start-up");
  a_user_hold: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    cas_ctrl_in[`SRA_CAS_USER_BIT] && !tbl_we_in |=>
      nibble[$past(cur_entry)] == $past(nibble[cur_entry]))
    else $error("user nibble overwritten");
  a_sync_hold: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    !sn_sync_in && !tbl_we_in |=>
      nibble[$past(cur_entry)] == $past(nibble[cur_entry]))
    else $error("nibble updated while out of sync");
  a_slip_reload: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    slipped && !last_ch |=> wr_ptr == $past(slip_ptr_in))
    else $error("slip did not reposition pointer");
  a_count_step: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    cell_tick |=> cell_count == $past(cell_count) + 16'h0001)
    else $error("overall counter did not step");
  a_roll_set: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    all_wrap |=> overall_roll && cell_count == 16'h0000)
    else $error("rollover status not set");
  a_vc_source: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    vc_wrap |=> vc_roll && source_reg == 16'($past(vc_struct_addr_in)))
    else $error("source address not captured");
  a_changed_set: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    cas_diff |=> changed_flag_out)
    else $error("changed flag not set");
  a_flag_nocas: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    !cas_on |-> !entry[15])
    else $error("multiframe flag set without signalling");
  a_turn_bits: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    entry[13:12] == use_ptr[WPW-1 -: 2])
    else $error("turn field mismatch");
  // Checked after the FIFO, where packing slips would show
  a_turn_out: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    buf_we_out |-> buf_data_out[13:12] == buf_addr_out[WPW-1 -: 2])
    else $error("turn field lost on the write port");
  a_first_free: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    take && cell_start_in && first_cell |-> !slipped)
    else $error("first cell was slip-checked");
  a_ovf_count: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    slipped && slip == SRA_OVERFLOW |=>
      overflow_cnt_out == $past(overflow_cnt_out) + 16'h0001)
    else $error("overflow statistic did not step");
  a_unr_count: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    slipped && slip == SRA_UNDERRUN |=>
      underrun_cnt_out == $past(underrun_cnt_out) + 16'h0001)
    else $error("underrun statistic did not step");
  a_no_request: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    !overall_roll && !vc_roll |=> !service_req_out)
    else $error("service request without a rollover");
  a_service_req: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    vc_roll && enable_reg[`SRA_VC_ROLL_BIT] |=> service_req_out)
    else $error("circuit rollover raised no request");
  a_roll_hold: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    overall_roll && !clr_all |=> overall_roll)
    else $error("rollover status dropped without a clear");
  a_changed_hold: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    changed_flag_out |=> changed_flag_out)
    else $error("changed flag dropped");
  a_wrap_frame: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    take && last_ch && in_cas && !vc_startup_in |=>
      cur_frame == 5'd0 && mf_pending)
    else $error("frame counter did not wrap after signalling");
  a_cas_store: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    cas_write && !tbl_we_in |=>
      nibble[$past(cur_entry)] == $past(rx_nib))
    else $error("received nibble not stored");
  c_slip: cover property (@(posedge clk_in) disable iff (!resetn_in) slipped);
  c_cas: cover property (@(posedge clk_in) disable iff (!resetn_in) cas_write);
  c_roll: cover property (@(posedge clk_in) disable iff (!resetn_in) all_wrap);
  c_full: cover property (@(posedge clk_in) disable iff (!resetn_in)
    cell_valid_in && !cell_ready_out);
  c_mf: cover property (@(posedge clk_in) disable iff (!resetn_in)
    payload && mf_bit);
endmodule : sra_engine

// ===== rtl/sra_regs.svh
// Register offsets, field positions, reset values and signalling frame counts
// Assumes a 16-bit host register port at byte addresses
`ifndef SRA_REGS_SVH
`define SRA_REGS_SVH
`define SRA_SERVICE_ENABLE_ADDR 14'h2042
`define SRA_SERVICE_SOURCE_ADDR 14'h2044
`define SRA_CELL_COUNT_STATUS_ADDR 14'h2046
`define SRA_CELL_COUNT_ADDR 14'h2048
`define SRA_ENABLE_RESET 16'h0000
`define SRA_OVERALL_ROLL_BIT 0
`define SRA_VC_ROLL_BIT 1
`define SRA_CAS_PROCESS_BIT 0
`define SRA_CAS_USER_BIT 1
`define SRA_CAS_COMPARE_BIT 2
`define SRA_E1_CAS_FRAME 5'd16
`define SRA_DS1_CAS_FRAME 5'd24
`endif

// ===== rtl/sra_pkg.sv
// Types shared by the structured reassembly engine
// Assumes the constants header is included by users of offsets
package sra_pkg;
  typedef enum logic [2:0] {
    SRA_OKAY     = 3'b001,
    SRA_OVERFLOW = 3'b010,
    SRA_UNDERRUN = 3'b100
  } sra_slip_t;
endpackage : sra_pkg

// ===== rtl/sra_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
// Assumes a single clock and active-low asynchronous reset
`timescale 1ns/100ps
module sra_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;
  // Full at DEPTH entries; an empty FIFO must accept
  assign in_ready_out  = (count < (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_idx];
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (push) wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
      if (pop)  rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) mem[wr_idx] <= in_data_in;
  end
endmodule : sra_fifo

// ===== verif/sra_far_model.sv
// Far-side model: output module taking circular buffer writes
// Assumes the bench drives the stall level after a rising edge
`timescale 1ns/100ps
module sra_far_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Stall request from the bench
  input  wire logic        stall_in,
  // Buffer write side
  input  wire logic        buf_we_in,
  input  wire logic [19:0] buf_addr_in,
  input  wire logic [15:0] buf_data_in,
  output logic             buf_ready_out
);
  // =====================================================
  // Capture of every write, in arrival order
  logic [19:0] q_addr[$];
  logic [15:0] q_data[$];
  // Stalling is the only way this reader misbehaves
  assign buf_ready_out = !stall_in;
  always @(posedge clk_in) begin
    if (resetn_in && buf_we_in === 1'b1) begin
      q_addr.push_back(buf_addr_in);
      q_data.push_back(buf_data_in);
    end
  end
endmodule : sra_far_model

// ===== verif/sra_engine_tb_top.sv
// Self-checking bench for the structured reassembly engine
// Assumes default engine parameters: 8 channels, 8-bit pointers
`timescale 1ns/100ps
`include "sra_regs.svh"
module sra_engine_tb_top;
  import sra_pkg::*;
  typedef struct packed {
    logic [2:0] ctrl; logic e1; logic sync; logic rf;
    logic [3:0] nib; logic mf; logic chg; logic full;
  } sra_row_t;
  logic clk_in, resetn_in, valid, ready, start, odd, csi, startup;
  logic e1, sync, rf, tbl_we, rd, wr, we, bready, stall, chg;
  logic adapt, srts, pv, rv, phase_seen;
  logic [2:0]  cas;
  logic [2:0]  last, idx;
  logic [7:0]  byt, slip, lead, rptr, pw, pw_got;
  logic [3:0]  nib, rts, rts_got;
  logic [11:0] base;
  logic [13:0] addr;
  logic [15:0] wdata, rdata, bdata, urun, oflow, got;
  logic [19:0] baddr;
  logic        sreq;
  int          errors, comparisons, cycles, n, k;
  sra_row_t    rows[8] = '{
    '{3'b000,1'b1,1'b1,1'b0,4'ha,1'b0,1'b0,1'b1},
    '{3'b001,1'b1,1'b1,1'b0,4'h5,1'b1,1'b0,1'b1},
    '{3'b001,1'b0,1'b1,1'b0,4'h5,1'b1,1'b0,1'b1},
    '{3'b011,1'b1,1'b1,1'b0,4'ha,1'b1,1'b0,1'b1},
    '{3'b101,1'b1,1'b1,1'b0,4'h5,1'b1,1'b1,1'b1},
    '{3'b111,1'b1,1'b1,1'b0,4'ha,1'b1,1'b1,1'b1},
    '{3'b101,1'b1,1'b0,1'b0,4'ha,1'b0,1'b0,1'b0},
    '{3'b101,1'b1,1'b1,1'b1,4'ha,1'b0,1'b0,1'b0}};
  logic [7:0]  rd_tab[4] = '{8'h3f, 8'h3f, 8'h00, 8'h41};
  logic [7:0]  wp_tab[4] = '{8'h40, 8'h41, 8'h40, 8'h40};
  sra_engine #(.CH(8), .WPW(8), .ADW(14), .DEPTH(16)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .cell_valid_in(valid),
    .cell_ready_out(ready), .cell_byte_in(byt), .cell_start_in(start),
    .cell_seq_odd_in(odd), .cell_csi_in(csi), .vc_startup_in(startup),
    .cas_ctrl_in(cas), .e1_mode_in(e1), .sn_sync_in(sync),
    .reframe_pend_in(rf), .last_entry_in(last), .slip_ptr_in(slip),
    .max_lead_in(lead), .read_ptr_in(rptr), .adaptive_en_in(adapt),
    .srts_en_in(srts), .vc_struct_addr_in(14'h0150), .tbl_we_in(tbl_we),
    .tbl_idx_in(idx), .tbl_nibble_in(nib), .tbl_base_in(base),
    .reg_rd_in(rd), .reg_wr_in(wr), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .buf_we_out(we),
    .buf_addr_out(baddr), .buf_data_out(bdata), .buf_ready_in(bready),
    .changed_flag_out(chg), .underrun_cnt_out(urun),
    .overflow_cnt_out(oflow), .service_req_out(sreq),
    .phase_valid_out(pv), .phaseword_out(pw), .rts_valid_out(rv),
    .rts_out(rts));
  sra_far_model i_far (.clk_in(clk_in), .resetn_in(resetn_in),
    .stall_in(stall), .buf_we_in(we), .buf_addr_in(baddr),
    .buf_data_in(bdata), .buf_ready_out(bready));
  // =====================================================
  // Clock, hang guard, pulse capture
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
    if (!resetn_in) phase_seen <= 1'b0;
    else if (pv === 1'b1) phase_seen <= 1'b1;
    if (pv === 1'b1 && phase_seen !== 1'b1) pw_got <= pw;
    if (rv === 1'b1) rts_got <= rts;
  end
  // =====================================================
  // Shared tasks
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic reset_dut();
    resetn_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    i_far.q_addr.delete();
    i_far.q_data.delete();
  endtask : reset_dut
  task automatic reg_rd(input logic [13:0] a);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
    got = rdata;
  endtask : reg_rd
  task automatic reg_wr(input logic [13:0] a, input logic [15:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask : reg_wr
  task automatic tload(input logic [2:0] i, input logic [3:0] v);
    tbl_we <= 1'b1;
    idx <= i;
    nib <= v;
    base <= 12'h100 + i;
    @(posedge clk_in);
    tbl_we <= 1'b0;
    @(posedge clk_in);
  endtask : tload
  task automatic kick();
    startup <= 1'b1;
    @(posedge clk_in);
    startup <= 1'b0;
    @(posedge clk_in);
  endtask : kick
  // Leaves valid high so back-to-back bytes need no idle cycle
  task automatic send(input logic [7:0] b, input logic st);
    int t;
    t = 0;
    valid <= 1'b1;
    byt <= b;
    start <= st;
    do begin
      @(posedge clk_in);
      t++;
    end while (ready !== 1'b1 && t < 200);
    if (t >= 200) chk(20'h1, 20'h0);
  endtask : send
  task automatic drain(input int want);
    int t;
    valid <= 1'b0;
    start <= 1'b0;
    for (t = 0; t < 300 && i_far.q_data.size() < want; t++)
      @(posedge clk_in);
    repeat (4) @(posedge clk_in);
  endtask : drain
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // =====================================================
  // Sequence
  initial begin
    {resetn_in, valid, start, odd, csi, startup, e1, sync, rf} = '0;
    {tbl_we, rd, wr, stall, adapt, srts, idx, nib, base, cas} = '0;
    {last, byt, addr, wdata, rptr} = '0;
    slip = 8'h40;
    lead = 8'h10;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    @(posedge clk_in);
    reset_dut();
    chk(ready, 1'b1);
    reg_rd(`SRA_SERVICE_ENABLE_ADDR);
    chk(got, `SRA_ENABLE_RESET);
    reg_rd(`SRA_CELL_COUNT_ADDR);
    chk(got, 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      reset_dut();
      cas <= rows[i].ctrl;
      e1 <= rows[i].e1;
      sync <= rows[i].sync;
      rf <= rows[i].rf;
      rptr <= 8'h3f;
      tload(3'd0, 4'ha);
      kick();
      k = rows[i].e1 ? 16 : 24;
      for (n = 0; n <= k; n++)
        send(n == k ? 8'h3c : (n == k - 1 ? 8'h05 : n[7:0]), n == 0);
      drain(k);
      n = i_far.q_data.size();
      got = n > 0 ? i_far.q_data[n-1] : 16'hxxxx;
      if (!rows[i].full) got[15] = 1'b0;
      chk(got, {rows[i].mf, 3'b001, rows[i].nib, 8'h3c});
      if (rows[i].full) chk(n, rows[i].ctrl[0] ? k : k + 1);
      chk(chg, rows[i].chg);
      $display("signalling row %0d done", i);
    end
    reset_dut();
    {cas, last, adapt, srts, odd, csi} <= {3'b000, 3'd3, 4'hf};
    for (n = 0; n < 4; n++) tload(n[2:0], 4'h0);
    kick();
    for (k = 0; k < 4; k++) begin
      rptr <= rd_tab[k];
      for (n = 0; n < 4; n++) send(8'h10 + n[7:0], n == 0);
    end
    drain(16);
    chk(i_far.q_data.size(), 16);
    for (k = 0; k < 16 && k < i_far.q_data.size(); k++) begin
      chk(i_far.q_addr[k], {12'h100 + k[1:0], wp_tab[k/4]});
      chk(i_far.q_data[k], {8'h10, 8'h10 + k[1:0]});
    end
    chk(oflow, 16'h0001);
    chk(urun, 16'h0001);
    chk(phase_seen, 1'b1);
    chk(pw_got, 8'h01);
    chk(rts_got, 4'hf);
    $display("slip test done");
    reg_wr(`SRA_CELL_COUNT_ADDR, 16'hffff);
    reg_rd(`SRA_CELL_COUNT_ADDR);
    chk(got, 16'h0004);
    reg_rd(14'h2000);
    chk(got, 16'h0000);
    reg_wr(`SRA_SERVICE_ENABLE_ADDR, 16'h0003);
    reg_rd(`SRA_SERVICE_ENABLE_ADDR);
    chk(got, 16'h0003);
    reg_rd(`SRA_CELL_COUNT_STATUS_ADDR);
    chk(got, 16'h0000);
    chk(sreq, 1'b0);
    $display("register test done");
    reset_dut();
    last <= 3'd0;
    kick();
    stall <= 1'b1;
    valid <= 1'b1;
    start <= 1'b1;
    n = 0;
    for (k = 0; k < 40; k++) begin
      byt <= n[7:0];
      @(posedge clk_in);
      if (ready === 1'b1) n++;
      start <= 1'b0;
    end
    chk(ready, 1'b0);
    chk(n >= 16 && n <= 18, 1'b1);
    stall <= 1'b0;
    drain(n);
    chk(i_far.q_data.size(), n);
    for (k = 0; k < n && k < i_far.q_data.size(); k++)
      chk(i_far.q_data[k][7:0], k[7:0]);
    $display("back-pressure test done");
    print_verdict();
  end
endmodule : sra_engine_tb_top
